//--- bench/aets_host_model.sv
// Purpose: Host model driving the byte access port
// Assumes: Requests launched at the falling edge
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/1ps
module aets_host_model (
	// Clock
	input  wire logic       i_mclk,
	// Request side
	output logic            o_req,
	output logic            o_we,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_wdata,
	// Answer side
	input  wire logic       i_rvalid,
	input  wire logic [7:0] i_rdata
);
	// ----
	// Bus idle and release
	// ----
	initial begin
		o_req   = 1'b0;
		o_we    = 1'b0;
		o_addr  = 8'h00;
		o_wdata = 8'h00;
	end

	// Inverted lines, so stale values never match by luck
	task automatic drop();
		o_req   = 1'b0;
		o_we    = ~o_we;
		o_addr  = ~o_addr;
		o_wdata = ~o_wdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		o_req   = 1'b1;
		o_we    = 1'b1;
		o_addr  = a;
		o_wdata = d;
		@(negedge i_mclk);
		drop();
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		int k;
		@(negedge i_mclk);
		o_req  = 1'b1;
		o_we   = 1'b0;
		o_addr = a;
		@(negedge i_mclk);
		drop();
		k = 0;
		while (i_rvalid !== 1'b1 && k < 4) begin
			@(negedge i_mclk);
			k++;
		end
		ok = (i_rvalid === 1'b1);
		d  = i_rdata;
	endtask

	// four entry bytes, high byte first
	task automatic enter_pw(input logic [31:0] pw);
		wr(aets_pkg::PWE_LO, pw[31:24]);
		wr(aets_pkg::PWE_LO + 8'h01, pw[23:16]);
		wr(aets_pkg::PWE_LO + 8'h02, pw[15:8]);
		wr(aets_pkg::PWE_HI, pw[7:0]);
	endtask
endmodule

//--- bench/alarm_enable_table_select_bank_tb_top.sv
// Purpose: Self-checking bench of the table select and enable bank
// Assumes: Host model issues all register traffic
// Notes:   Stored passwords differ from the all-ones entry value
`timescale 1ns/1ps
module alarm_enable_table_select_bank_tb_top;
	localparam logic [31:0] PW_LO = 32'h1122_3344;
	localparam logic [31:0] PW_HI = 32'h5566_7788;
	logic       mclk, arst_n, req, we, rvalid, shadow, reloc, fint, lgate, ee_wr;
	logic [7:0] addr, wdata, rdata, ee_addr, ee_data, sel_out, pon;
	logic [5:0] grant;
	logic [7:0] st [5];
	int         fail_count, cmp_count, ee_cnt;

	// ----
	// Clock, design and host
	// ----
	always #20 mclk = ~mclk;

	aets_bank u_dut (
		.i_mclk(mclk), .i_arst_n(arst_n), .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wdata),
		.o_rvalid(rvalid), .o_rdata(rdata), .i_lower_password_level(PW_LO),
		.i_higher_password_level(PW_HI), .i_area_a_readwrite_grant(grant[0]),
		.i_area_a_readonly_grant(grant[1]), .i_area_b_readwrite_grant(grant[2]),
		.i_area_b_readonly_grant(grant[3]), .i_enables_readwrite_grant(grant[4]),
		.i_enables_readonly_grant(grant[5]), .i_selector_power_on_value(pon),
		.i_enable_relocate(reloc), .i_shadow_write_disable(shadow), .i_alarm_env(st[0]),
		.i_alarm_mon(st[1]), .i_alarm_laser(st[2]), .i_alarm_signal(st[3]), .i_warning_env(st[4]),
		.o_fault_interrupt_out(fint), .o_laser_fault_gate(lgate), .o_ee_write(ee_wr),
		.o_ee_addr(ee_addr), .o_ee_data(ee_data), .o_upper_table_selector(sel_out)
	);

	aets_host_model u_host (
		.i_mclk(mclk), .o_req(req), .o_we(we), .o_addr(addr), .o_wdata(wdata),
		.i_rvalid(rvalid), .i_rdata(rdata)
	);

	always @(posedge mclk) begin
		if (ee_wr === 1'b1) begin
			ee_cnt++;
		end
	end

	// ----
	// Compare and report
	// ----
	task automatic close_out();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cmp1(input string n, input logic e, input logic g);
		cmp8(n, {7'h00, e}, {7'h00, g});
	endtask

	// Bus read with its answer judged; a lost answer ends the run
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		u_host.rd(a, d, ok);
		if (!ok) begin
			cmp1({n, "_answer"}, 1'b1, ok);
			close_out();
		end else begin
			cmp8(n, e, d);
		end
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_power_on();
		cmp8("selector", 8'h01, sel_out);
		cmp1("idle_int", 1'b0, fint);
		rchk("pwe_read", 8'h7B, 8'h00);
		rchk("en_locked", 8'hF8, 8'h00);
		u_host.enter_pw(PW_HI);
		for (int i = 0; i < 5; i++) begin
			rchk("en_reset", 8'hF8 + 8'(i), 8'h00);
		end
		rchk("pwe_after", 8'h7E, 8'h00);
	endtask

	task automatic t_table_select();
		u_host.wr(8'h7F, 8'h02);
		rchk("sel_read", 8'h7F, 8'h02);
		cmp8("sel_out", 8'h02, sel_out);
		u_host.wr(8'h80, 8'h77);
		u_host.wr(8'h7F, 8'h01);
		rchk("area_hidden", 8'h80, 8'h00);
	endtask

	task automatic t_gates();
		logic [7:0] a [5] = '{8'h80, 8'hBF, 8'hC0, 8'hF7, 8'hFC};
		int         p [5] = '{0, 0, 1, 1, 2};
		int         e0;
		for (int i = 0; i < 5; i++) begin
			u_host.enter_pw(PW_LO);
			grant = 6'h00;
			e0 = ee_cnt;
			u_host.wr(a[i], 8'h5A);
			rchk("no_grant", a[i], 8'h00);
			grant[2 * p[i]] = 1'b1;
			u_host.wr(a[i], 8'h5A);
			rchk("rw_grant", a[i], 8'h5A);
			grant = 6'h00;
			grant[2 * p[i] + 1] = 1'b1;
			u_host.wr(a[i], 8'hA5);
			rchk("ro_grant", a[i], 8'h5A);
			grant = 6'h3F ^ (6'h03 << (2 * p[i]));
			rchk("other_pair", a[i], 8'h00);
			grant = 6'h00;
			u_host.enter_pw(PW_HI);
			u_host.wr(a[i], 8'hA5);
			rchk("higher", a[i], 8'hA5);
			cmp8("ee_count", 8'h02, 8'(ee_cnt - e0));
		end
	endtask

	task automatic t_reserved();
		logic [7:0] a [4] = '{8'hF9, 8'hFA, 8'hFB, 8'hFD};
		logic [7:0] e [4] = '{8'hF0, 8'h0B, 8'hC8, 8'h00};
		for (int i = 0; i < 4; i++) begin
			u_host.wr(a[i], 8'hFF);
			rchk("reserved", a[i], e[i]);
		end
	endtask

	task automatic fault(input logic [7:0] a, input logic [7:0] en, input int idx, input logic [7:0] s,
		input logic ei, input logic eg);
		u_host.wr(a, en);
		st[idx] = s;
		@(negedge mclk);
		@(negedge mclk);
		cmp1("fault_int", ei, fint);
		cmp1("laser_gate", eg, lgate);
		st[idx] = 8'h00;
	endtask

	task automatic t_faults();
		for (int n = 0; n < 8; n++) begin
			fault(8'hF8, 8'h01 << n, 0, 8'h01 << n, 1'b1, 1'b0);
			fault(8'hF8, ~(8'h01 << n), 0, 8'h01 << n, 1'b0, 1'b0);
			fault(8'hFC, 8'h01 << n, 4, 8'h01 << n, 1'b1, 1'b0);
		end
		fault(8'hF9, 8'hF0, 1, 8'hF0, 1'b1, 1'b0);
		fault(8'hF9, 8'hFF, 1, 8'h0F, 1'b0, 1'b0);
		fault(8'hFA, 8'h08, 2, 8'h08, 1'b0, 1'b1);
		fault(8'hFA, 8'h03, 2, 8'h03, 1'b0, 1'b1);
		fault(8'hFA, 8'hFF, 2, 8'hF4, 1'b0, 1'b0);
		fault(8'hFB, 8'hC0, 3, 8'hC0, 1'b1, 1'b0);
		fault(8'hFB, 8'h30, 3, 8'h30, 1'b0, 1'b0);
		fault(8'hFB, 8'h08, 3, 8'h08, 1'b0, 1'b1);
	endtask

	task automatic t_shadow_reloc();
		int e0;
		shadow = 1'b1;
		e0 = ee_cnt;
		u_host.wr(8'hF8, 8'h3C);
		rchk("shadow_kept", 8'hF8, 8'h3C);
		cmp8("ee_skip", 8'h00, 8'(ee_cnt - e0));
		shadow = 1'b0;
		u_host.wr(8'hF8, 8'hC3);
		@(negedge mclk);
		cmp8("ee_commit", 8'h01, 8'(ee_cnt - e0));
		cmp8("ee_addr", 8'hF8, ee_addr);
		cmp8("ee_data", 8'hC3, ee_data);
		reloc = 1'b1;
		rchk("moved_away", 8'hF8, 8'h00);
		u_host.wr(8'h7F, 8'h05);
		rchk("alt_table", 8'hF8, 8'hC3);
		reloc = 1'b0;
		u_host.wr(8'h7F, 8'h01);
		rchk("main_table", 8'hF8, 8'hC3);
	endtask

	// Second reset with another stored table number
	task automatic t_reset_again();
		u_host.enter_pw(PW_LO);
		rchk("en_locked_set", 8'hF8, 8'h00);
		grant[5] = 1'b1;
		rchk("en_readonly", 8'hF8, 8'hC3);
		grant = 6'h00;
		pon = 8'h05;
		arst_n = 1'b0;
		repeat (2) @(negedge mclk);
		cmp8("sel_in_reset", 8'h00, sel_out);
		arst_n = 1'b1;
		repeat (3) @(negedge mclk);
		cmp8("sel_reload", 8'h05, sel_out);
		u_host.enter_pw(PW_HI);
		reloc = 1'b1;
		rchk("en_cleared", 8'hF8, 8'h00);
		rchk("sel_reread", 8'h7F, 8'h05);
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		mclk = 1'b0;
		arst_n = 1'b0;
		shadow = 1'b0;
		reloc = 1'b0;
		grant = 6'h00;
		pon = 8'h01;
		st = '{default: 8'h00};
		repeat (8) @(negedge mclk);
		arst_n = 1'b1;
		repeat (3) @(negedge mclk);
		t_power_on();
		t_table_select();
		t_gates();
		t_reserved();
		t_faults();
		t_shadow_reloc();
		t_reset_again();
		close_out();
	end

	// Hang guard
	initial begin
		#2000000;
		fail_count++;
		close_out();
	end
endmodule

//--- rtl/aets_bank.sv
// Purpose: Table select, user areas and alarm enables of the module controller
// Assumes: A serial front end delivers decoded byte reads and writes
// Notes:   Grant bits, passwords and status flags come from same-clock logic
`timescale 1ns/1ps
module aets_bank (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_arst_n,
	// Byte access from the serial front end
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	output logic             o_rvalid,
	output logic [7:0]       o_rdata,
	// Stored passwords and grants
	input  wire logic [31:0] i_lower_password_level,
	input  wire logic [31:0] i_higher_password_level,
	input  wire logic        i_area_a_readwrite_grant,
	input  wire logic        i_area_a_readonly_grant,
	input  wire logic        i_area_b_readwrite_grant,
	input  wire logic        i_area_b_readonly_grant,
	input  wire logic        i_enables_readwrite_grant,
	input  wire logic        i_enables_readonly_grant,
	// Other table settings
	input  wire logic [7:0]  i_selector_power_on_value,
	input  wire logic        i_enable_relocate,
	input  wire logic        i_shadow_write_disable,
	// Monitor status flags
	input  wire logic [7:0]  i_alarm_env,
	input  wire logic [7:0]  i_alarm_mon,
	input  wire logic [7:0]  i_alarm_laser,
	input  wire logic [7:0]  i_alarm_signal,
	input  wire logic [7:0]  i_warning_env,
	// Fault outputs
	output logic             o_fault_interrupt_out,
	output logic             o_laser_fault_gate,
	// EEPROM commit request
	output logic             o_ee_write,
	output logic [7:0]       o_ee_addr,
	output logic [7:0]       o_ee_data,
	// Current table
	output logic [7:0]       o_upper_table_selector
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [31:0] password_entry_bytes;
	logic        sel_loaded;
	logic [7:0]  area_a [0:aets_pkg::AREA_A_DEPTH-1];
	logic [7:0]  area_b [0:aets_pkg::AREA_B_DEPTH-1];
	logic [7:0]  en_env, en_mon, en_las, en_sig, wen_env;
	logic [7:0]  next_rdata;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	logic       wr_take, acc_sel, acc_pwe, tbl_main, tbl_en, in_a, in_b, in_en;
	logic [7:0] en_table;
	logic [1:0] pwe_lane;
	logic [5:0] a_idx, b_idx;

	assign wr_take  = i_req & i_we;
	assign acc_sel  = (i_addr == aets_pkg::SEL_ADDR);
	assign acc_pwe  = (i_addr >= aets_pkg::PWE_LO) && (i_addr <= aets_pkg::PWE_HI);
	assign tbl_main = (o_upper_table_selector == aets_pkg::TBL_MAIN);
	assign en_table = i_enable_relocate ? aets_pkg::TBL_ALT : aets_pkg::TBL_MAIN;
	assign tbl_en   = (o_upper_table_selector == en_table);
	assign in_a     = tbl_main && (i_addr >= aets_pkg::AREA_A_LO) && (i_addr <= aets_pkg::AREA_A_HI);
	assign in_b     = tbl_main && (i_addr >= aets_pkg::AREA_B_LO) && (i_addr <= aets_pkg::AREA_B_HI);
	assign in_en    = tbl_en && (i_addr >= aets_pkg::EN_ENV) && (i_addr <= aets_pkg::WEN_ENV);
	assign pwe_lane = 2'(aets_pkg::PWE_HI - i_addr);
	assign a_idx    = 6'(i_addr - aets_pkg::AREA_A_LO);
	assign b_idx    = 6'(i_addr - aets_pkg::AREA_B_LO);

	// ---------------------------------------------------------------
	// Password levels and grants
	// ---------------------------------------------------------------
	logic hi_ok, lo_ok, rd_ok_a, wr_ok_a, rd_ok_b, wr_ok_b, rd_ok_c, wr_ok_c;

	// Higher match also counts as lower
	assign hi_ok = (password_entry_bytes == i_higher_password_level);
	assign lo_ok = hi_ok | (password_entry_bytes == i_lower_password_level);

	aets_grant u_grant_a (.i_higher_ok(hi_ok), .i_lower_ok(lo_ok), .i_rw_grant(i_area_a_readwrite_grant),
		.i_ro_grant(i_area_a_readonly_grant), .o_read_ok(rd_ok_a), .o_write_ok(wr_ok_a));

	aets_grant u_grant_b (.i_higher_ok(hi_ok), .i_lower_ok(lo_ok), .i_rw_grant(i_area_b_readwrite_grant),
		.i_ro_grant(i_area_b_readonly_grant), .o_read_ok(rd_ok_b), .o_write_ok(wr_ok_b));

	aets_grant u_grant_c (.i_higher_ok(hi_ok), .i_lower_ok(lo_ok), .i_rw_grant(i_enables_readwrite_grant),
		.i_ro_grant(i_enables_readonly_grant), .o_read_ok(rd_ok_c), .o_write_ok(wr_ok_c));

	// ---------------------------------------------------------------
	// Password entry
	// ---------------------------------------------------------------
	// Entry bytes start as all ones
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			password_entry_bytes <= aets_pkg::PWE_RESET;
		end else if (wr_take && acc_pwe) begin
			password_entry_bytes[{pwe_lane, 3'h0} +: 8] <= i_wdata;
		end
	end

	// ---------------------------------------------------------------
	// Table selector
	// ---------------------------------------------------------------
	// Stored value is caught after release, never under reset
	// First edge loads the power-on table
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sel_loaded             <= 1'b0;
			o_upper_table_selector <= aets_pkg::SEL_RESET;
		end else if (!sel_loaded) begin
			sel_loaded             <= 1'b1;
			o_upper_table_selector <= i_selector_power_on_value;
		end else if (wr_take && acc_sel) begin
			o_upper_table_selector <= i_wdata;
		end
	end

	// ---------------------------------------------------------------
	// User areas
	// ---------------------------------------------------------------
	// Area A write needs write permission
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < aets_pkg::AREA_A_DEPTH; i++) begin
				area_a[i] <= aets_pkg::AREA_RESET;
			end
		end else if (wr_take && in_a && wr_ok_a) begin
			area_a[a_idx] <= i_wdata;
		end
	end

	// Area B write needs write permission
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < aets_pkg::AREA_B_DEPTH; i++) begin
				area_b[i] <= aets_pkg::AREA_RESET;
			end
		end else if (wr_take && in_b && wr_ok_b) begin
			area_b[b_idx] <= i_wdata;
		end
	end

	// ---------------------------------------------------------------
	// Enable registers
	// ---------------------------------------------------------------
	// All enables off after power on
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			en_env  <= aets_pkg::EN_RESET;
			en_mon  <= aets_pkg::EN_RESET;
			en_las  <= aets_pkg::EN_RESET;
			en_sig  <= aets_pkg::EN_RESET;
			wen_env <= aets_pkg::EN_RESET;
		end else if (wr_take && in_en && wr_ok_c) begin
			case (i_addr)
				aets_pkg::EN_ENV:  en_env  <= i_wdata & aets_pkg::MASK_ENV;
				aets_pkg::EN_MON:  en_mon  <= i_wdata & aets_pkg::MASK_MON;
				aets_pkg::EN_LAS:  en_las  <= i_wdata & aets_pkg::MASK_LAS;
				aets_pkg::EN_SIG:  en_sig  <= i_wdata & aets_pkg::MASK_SIG;
				aets_pkg::WEN_ENV: wen_env <= i_wdata & aets_pkg::MASK_ENV;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// EEPROM commit
	// ---------------------------------------------------------------
	logic ee_go;

	// Shadow disable keeps enables volatile only
	assign ee_go = wr_take && ((in_a && wr_ok_a) || (in_b && wr_ok_b)
		|| (in_en && wr_ok_c && !i_shadow_write_disable));

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ee_write <= 1'b0;
			o_ee_addr  <= aets_pkg::READ_ZERO;
			o_ee_data  <= aets_pkg::READ_ZERO;
		end else begin
			o_ee_write <= ee_go;
			if (ee_go) begin
				o_ee_addr <= i_addr;
				o_ee_data <= i_wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Refused reads answer zero rather than stalling the bus
	always_comb begin
		next_rdata = aets_pkg::READ_ZERO;
		if (acc_sel) begin
			next_rdata = o_upper_table_selector;
		end else if (in_a && rd_ok_a) begin
			next_rdata = area_a[a_idx];
		end else if (in_b && rd_ok_b) begin
			next_rdata = area_b[b_idx];
		end else if (in_en && rd_ok_c) begin
			case (i_addr)
				aets_pkg::EN_ENV:  next_rdata = en_env;
				aets_pkg::EN_MON:  next_rdata = en_mon;
				aets_pkg::EN_LAS:  next_rdata = en_las;
				aets_pkg::EN_SIG:  next_rdata = en_sig;
				aets_pkg::WEN_ENV: next_rdata = wen_env;
				default:           next_rdata = aets_pkg::READ_ZERO;
			endcase
		end
	end

	// Entry bytes fall to the zero default
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rvalid <= 1'b0;
			o_rdata  <= aets_pkg::READ_ZERO;
		end else begin
			o_rvalid <= i_req & ~i_we;
			if (i_req && !i_we) begin
				o_rdata <= next_rdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// Fault masking
	// ---------------------------------------------------------------
	logic hit_env, hit_mon, hit_sig, hit_wrn, hit_las, hit_bias;

	// Bit n of enable masks bit n of status
	aets_mask #(.USED(aets_pkg::MASK_ENV)) u_mask_env (
		.i_status(i_alarm_env), .i_enable(en_env), .o_hit(hit_env));
	aets_mask #(.USED(aets_pkg::MASK_MON)) u_mask_mon (
		.i_status(i_alarm_mon), .i_enable(en_mon), .o_hit(hit_mon));
	// Signal loss alarms to the interrupt
	aets_mask #(.USED(aets_pkg::INT_SIG)) u_mask_sig (
		.i_status(i_alarm_signal), .i_enable(en_sig), .o_hit(hit_sig));
	aets_mask #(.USED(aets_pkg::MASK_ENV)) u_mask_wrn (
		.i_status(i_warning_env), .i_enable(wen_env), .o_hit(hit_wrn));
	// Bias and transmit power to the gate
	aets_mask #(.USED(aets_pkg::MASK_LAS)) u_mask_las (
		.i_status(i_alarm_laser), .i_enable(en_las), .o_hit(hit_las));
	// Bias ceiling to the gate only
	aets_mask #(.USED(aets_pkg::GATE_SIG)) u_mask_bias (
		.i_status(i_alarm_signal), .i_enable(en_sig), .o_hit(hit_bias));

	// Registered outputs, one cycle behind the flags
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_fault_interrupt_out <= 1'b0;
			o_laser_fault_gate    <= 1'b0;
		end else begin
			o_fault_interrupt_out <= hit_env | hit_mon | hit_sig | hit_wrn;
			o_laser_fault_gate    <= hit_las | hit_bias;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	sequence s_en_write;
		wr_take && in_en && wr_ok_c;
	endsequence
	sequence s_en_refused;
		wr_take && in_en && !wr_ok_c;
	endsequence

	a_sel_write: assert property (
		sel_loaded && wr_take && acc_sel |=> o_upper_table_selector == $past(i_wdata))
		else $error("selector did not take the written table");
	a_sel_poweron: assert property (
		!sel_loaded |=> sel_loaded && o_upper_table_selector == $past(i_selector_power_on_value))
		else $error("selector not loaded from power-on value");
	a_area_a_guard: assert property (
		wr_take && in_a && !wr_ok_a |=> !o_ee_write)
		else $error("refused area A write reached EEPROM");
	a_area_b_read: assert property (
		i_req && !i_we && in_b && !rd_ok_b |=> o_rvalid && o_rdata == aets_pkg::READ_ZERO)
		else $error("refused area B read returned data");
	a_enable_guard: assert property (
		s_en_refused |=> $stable(en_env) && $stable(en_mon) && $stable(en_las) && $stable(en_sig)
		&& $stable(wen_env))
		else $error("refused enable write changed state");
	a_mon_reserved: assert property (
		s_en_write ##0 (i_addr == aets_pkg::EN_MON) |=> en_mon == ($past(i_wdata) & aets_pkg::MASK_MON))
		else $error("monitor enable reserved bits stored");
	a_int_cause: assert property (
		(i_alarm_env & en_env) != 8'h00 |=> o_fault_interrupt_out)
		else $error("enabled alarm did not raise interrupt");
	a_gate_cause: assert property (
		(i_alarm_laser & en_las & aets_pkg::MASK_LAS) != 8'h00 |=> o_laser_fault_gate)
		else $error("enabled laser alarm did not raise gate");
	// Bias ceiling alone stays off the interrupt
	a_bias_route: assert property (
		i_alarm_signal == aets_pkg::GATE_SIG && en_sig[3] && !hit_env && !hit_mon && !hit_wrn
		|=> o_laser_fault_gate && !o_fault_interrupt_out)
		else $error("bias ceiling routed wrongly");
	a_pwe_read: assert property (
		i_req && !i_we && acc_pwe |=> o_rdata == aets_pkg::READ_ZERO)
		else $error("password entry read back nonzero");
	a_shadow_skip: assert property (
		s_en_write ##0 i_shadow_write_disable |=> !o_ee_write)
		else $error("shadow write reached EEPROM");
	// Relocated enables hidden in main table
	a_relocate: assert property (
		i_req && !i_we && i_enable_relocate && tbl_main && i_addr == aets_pkg::EN_ENV
		|=> o_rdata == aets_pkg::READ_ZERO)
		else $error("relocated enable visible in main table");

endmodule

//--- rtl/aets_grant.sv
// Purpose: Read and write permission for one password-gated area
// Assumes: Password match flags come from the same clock domain
// Notes:   Higher level always carries the lower level rights
`timescale 1ns/1ps
module aets_grant (
	// Password levels
	input  wire logic i_higher_ok,
	input  wire logic i_lower_ok,
	// Lower level grants
	input  wire logic i_rw_grant,
	input  wire logic i_ro_grant,
	// Permissions
	output logic      o_read_ok,
	output logic      o_write_ok
);
	assign o_read_ok  = i_higher_ok | (i_lower_ok & (i_rw_grant | i_ro_grant));
	assign o_write_ok = i_higher_ok | (i_lower_ok & i_rw_grant);
endmodule

//--- rtl/aets_mask.sv
// Purpose: Masks one status byte with its enable byte
// Assumes: Status and enable share the same bit layout
// Notes:   USED drops bits that do not feed this output
`timescale 1ns/1ps
module aets_mask #(
	parameter logic [7:0] USED = 8'hFF
) (
	// Status and enables
	input  wire logic [7:0] i_status,
	input  wire logic [7:0] i_enable,
	// Result
	output logic            o_hit
);
	assign o_hit = |(i_status & i_enable & USED);
endmodule

//--- rtl/aets_pkg.sv
// Purpose: Constants of the alarm enable and table select bank
// Assumes: Byte addresses of the upper and lower register map
// Notes:   Shared by the bank and the bench host model
package aets_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] SEL_ADDR   = 8'h7F;
	localparam logic [7:0] PWE_LO     = 8'h7B;
	localparam logic [7:0] PWE_HI     = 8'h7E;
	localparam logic [7:0] AREA_A_LO  = 8'h80;
	localparam logic [7:0] AREA_A_HI  = 8'hBF;
	localparam logic [7:0] AREA_B_LO  = 8'hC0;
	localparam logic [7:0] AREA_B_HI  = 8'hF7;
	localparam logic [7:0] EN_ENV     = 8'hF8;
	localparam logic [7:0] EN_MON     = 8'hF9;
	localparam logic [7:0] EN_LAS     = 8'hFA;
	localparam logic [7:0] EN_SIG     = 8'hFB;
	localparam logic [7:0] WEN_ENV    = 8'hFC;

	// ---------------------------------------------------------------
	// Table numbers and sizes
	// ---------------------------------------------------------------
	localparam logic [7:0] TBL_MAIN     = 8'h01;
	localparam logic [7:0] TBL_ALT      = 8'h05;
	localparam int         AREA_A_DEPTH = 32'h40;
	localparam int         AREA_B_DEPTH = 32'h38;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] PWE_RESET  = 32'hFFFF_FFFF;
	localparam logic [7:0]  SEL_RESET  = 8'h00;
	localparam logic [7:0]  EN_RESET   = 8'h00;
	localparam logic [7:0]  AREA_RESET = 8'h00;
	localparam logic [7:0]  READ_ZERO  = 8'h00;

	// ---------------------------------------------------------------
	// Implemented bits of each enable register, and the signal enable bits routed to each output
	// ---------------------------------------------------------------
	localparam logic [7:0] MASK_ENV = 8'hFF;
	localparam logic [7:0] MASK_MON = 8'hF0;
	localparam logic [7:0] MASK_LAS = 8'h0B;
	localparam logic [7:0] MASK_SIG = 8'hC8;
	localparam logic [7:0] INT_SIG  = 8'hC0;
	localparam logic [7:0] GATE_SIG = 8'h08;

endpackage
